// ### include/lps_pkg.sv
// Constants and types shared by the LO phase sync block
package lps_pkg;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned MCS_STAGES = 4;
  localparam int unsigned PLL_COUNT = 4;
  localparam int unsigned PHASE_W = 16;
  localparam int unsigned FRAC_W = 24;
  localparam int unsigned ACC_W = 32;
  localparam int unsigned AVG_LOG2 = 8;
  localparam logic [AVG_LOG2:0] AVG_COUNT = 9'h100;
  localparam logic [PHASE_W-1:0] STEP_MAX = 16'h0010;
  localparam logic [2:0] SYNC_RST = 3'h0;
  localparam logic [1:0] STAGE_RST = 2'h0;
  localparam logic [PHASE_W-1:0] PHASE_RST = 16'h0000;
  localparam logic [PLL_COUNT-1:0] MASK_RST = 4'h0;

  typedef enum logic [2:0] {
    LPS_IDLE,
    LPS_MCS,
    LPS_READY,
    LPS_MEASURE,
    LPS_CORRECT
  } lps_state_e;
endpackage : lps_pkg

// ### hw/lps_phase_sync.sv
// Multichip sync sequencer with LO phase measurement and correction
`timescale 1ns/1ps

module lps_phase_sync
  import lps_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Board sync pulse
  input wire logic sysref,
  // Control
  input wire logic mcs_start,
  input wire logic cal_start,
  input wire logic tracking_en,
  // LO programming
  input wire logic lo_program,
  input wire logic [FRAC_W-1:0] frac_word,
  input wire logic [7:0] loop_bw_set,
  input wire logic [7:0] loop_pm_set,
  // LO quadrature samples and PLL lock indications
  input wire logic lo_i,
  input wire logic lo_q,
  input wire logic [PLL_COUNT-1:0] pll_lock_raw,
  // Clock tree resets
  output logic [MCS_STAGES-1:0] stage_reset,
  output logic mcs_done,
  // Modulator correction and loop settings
  output logic [PHASE_W-1:0] sdm_offset,
  output logic [7:0] loop_bw,
  output logic [7:0] loop_pm,
  output logic [PHASE_W-1:0] desired_phase,
  output logic [PHASE_W-1:0] phase_error,
  output logic cal_done,
  // Interrupt masking and lock status
  output logic [PLL_COUNT-1:0] unlock_irq_mask,
  output logic [PLL_COUNT-1:0] pll_locked
);

  typedef struct packed {
    lps_state_e st;
    logic [2:0] sref_sync;
    logic [2:0] lo_i_sync;
    logic [2:0] lo_q_sync;
    logic lo_i_lvl;
    logic lo_q_lvl;
    logic [PLL_COUNT-1:0] lk1;
    logic [PLL_COUNT-1:0] lk2;
    logic [PLL_COUNT-1:0] lk3;
    logic sref_lvl;
    logic [1:0] stage;
    logic [MCS_STAGES-1:0] rst_pulse;
    logic done;
    logic [FRAC_W-1:0] counter;
    logic [FRAC_W-1:0] frac;
    logic [FRAC_W-1:0] desired_phase_accumulator;
    logic signed [ACC_W-1:0] acc_i;
    logic signed [ACC_W-1:0] acc_q;
    logic [AVG_LOG2:0] n;
    logic [PHASE_W-1:0] err;
    logic err_valid;
    logic [PHASE_W-1:0] remaining;
    logic [PHASE_W-1:0] sigma_delta_modulator;
    logic [7:0] bw;
    logic [7:0] pm;
    logic [PLL_COUNT-1:0] mask;
    logic [PLL_COUNT-1:0] locked;
    logic cal;
  } lps_s;

  lps_s q_r;
  lps_s q_nxt;

  // Quadrant of a phase word as a unit vector: 00=+1, 01=+j, 10=-1, 11=-j
  function automatic logic [1:0] lps_quadrant(input logic [PHASE_W-1:0] ph);
    lps_quadrant = ph[PHASE_W-1 -: 2];
  endfunction : lps_quadrant

  // Coarse angle of a vector as a phase word
  function automatic logic [PHASE_W-1:0] lps_angle(input logic signed [ACC_W-1:0] x,
                                                   input logic signed [ACC_W-1:0] y);
    logic [PHASE_W-1:0] a;
    a = 16'h0000;
    if (x >= 0 && y >= 0) begin
      if (y > x) begin
        a = 16'h3000;
      end else if (y == 0) begin
        a = 16'h0000;
      end else begin
        a = 16'h1000;
      end
    end else if (x < 0 && y >= 0) begin
      if (y > -x) begin
        a = 16'h5000;
      end else begin
        a = 16'h7000;
      end
    end else if (x < 0) begin
      if (-y > -x) begin
        a = 16'hB000;
      end else begin
        a = 16'h9000;
      end
    end else begin
      if (-y > x) begin
        a = 16'hD000;
      end else begin
        a = 16'hF000;
      end
    end
    lps_angle = a;
  endfunction : lps_angle

  // Opens a fresh averaging window
  function automatic lps_s lps_arm_measure(input lps_s s);
    lps_s t;
    t = s;
    t.st = LPS_MEASURE;
    t.acc_i = '0;
    t.acc_q = '0;
    t.n = '0;
    lps_arm_measure = t;
  endfunction : lps_arm_measure

  // Restarts the four-stage sync sequence
  function automatic lps_s lps_arm_sync(input lps_s s);
    lps_s t;
    t = s;
    t.st = LPS_MCS;
    t.stage = STAGE_RST;
    t.done = 1'b0;
    lps_arm_sync = t;
  endfunction : lps_arm_sync

  ////////////////////////////////////////////////////////////////////////////
  logic sref_rise;
  logic signed [1:0] smp_i;
  logic signed [1:0] smp_q;
  logic signed [1:0] rot_i;
  logic signed [1:0] rot_q;
  logic [PHASE_W-1:0] step;

  always_comb begin
    q_nxt = q_r;
    q_nxt.sref_sync = {q_r.sref_sync[1:0], sysref};
    q_nxt.lo_i_sync = {q_r.lo_i_sync[1:0], lo_i};
    q_nxt.lo_q_sync = {q_r.lo_q_sync[1:0], lo_q};
    q_nxt.lk1 = pll_lock_raw;
    q_nxt.lk2 = q_r.lk1;
    q_nxt.lk3 = q_r.lk2;
    if (q_r.sref_sync[2] == q_r.sref_sync[1]) begin
      q_nxt.sref_lvl = q_r.sref_sync[2];
    end
    sref_rise = (q_r.sref_sync[2] == q_r.sref_sync[1]) && q_r.sref_sync[2] && !q_r.sref_lvl;
    if (q_r.lo_i_sync[2] == q_r.lo_i_sync[1]) begin
      q_nxt.lo_i_lvl = q_r.lo_i_sync[2];
    end
    if (q_r.lo_q_sync[2] == q_r.lo_q_sync[1]) begin
      q_nxt.lo_q_lvl = q_r.lo_q_sync[2];
    end
    for (int k = 0; k < PLL_COUNT; k++) begin
      if (q_r.lk3[k] == q_r.lk2[k]) begin
        q_nxt.locked[k] = q_r.lk3[k];
      end
    end
    q_nxt.rst_pulse = '0;
    q_nxt.counter = q_r.counter + 24'h000001;
    q_nxt.desired_phase_accumulator = q_r.counter * q_r.frac;
    smp_i = q_r.lo_i_lvl ? 2'sb01 : 2'sb11;
    smp_q = q_r.lo_q_lvl ? 2'sb01 : 2'sb11;
    // multiply by conjugate of desired phase
    unique case (lps_quadrant(q_r.desired_phase_accumulator[FRAC_W-1 -: PHASE_W]))
      2'h0: begin
        rot_i = smp_i;
        rot_q = smp_q;
      end
      2'h1: begin
        rot_i = smp_q;
        rot_q = -smp_i;
      end
      2'h2: begin
        rot_i = -smp_i;
        rot_q = -smp_q;
      end
      2'h3: begin
        rot_i = -smp_q;
        rot_q = smp_i;
      end
    endcase
    step = (q_r.remaining > STEP_MAX) ? STEP_MAX : q_r.remaining;
    q_nxt.mask = lo_program ? {PLL_COUNT{1'b1}} : MASK_RST;
    if (lo_program) begin
      q_nxt.bw = loop_bw_set;
      q_nxt.pm = loop_pm_set;
      q_nxt.frac = frac_word;
    end
    unique case (q_r.st)
      LPS_IDLE: begin
        if (mcs_start) begin
          q_nxt = lps_arm_sync(q_nxt);
        end
      end
      LPS_MCS: begin
        if (sref_rise) begin
          q_nxt.rst_pulse[q_r.stage] = 1'b1;
          if (q_r.stage == 2'(MCS_STAGES - 1)) begin
            q_nxt.st = LPS_READY;
            q_nxt.done = 1'b1;
            // counter seeded on final sync edge
            q_nxt.counter = '0;
          end else begin
            q_nxt.stage = q_r.stage + 2'h1;
          end
        end
      end
      LPS_READY: begin
        if (mcs_start) begin
          q_nxt = lps_arm_sync(q_nxt);
        end else if (cal_start) begin
          q_nxt = lps_arm_measure(q_nxt);
          q_nxt.err_valid = 1'b0;
        end
      end
      LPS_MEASURE: begin
        q_nxt.acc_i = q_r.acc_i + ACC_W'(rot_i);
        q_nxt.acc_q = q_r.acc_q + ACC_W'(rot_q);
        q_nxt.n = q_r.n + 9'h001;
        if (q_r.n == AVG_COUNT - 9'h001) begin
          q_nxt.err = lps_angle(q_nxt.acc_i, q_nxt.acc_q);
          q_nxt.remaining = lps_angle(q_nxt.acc_i, q_nxt.acc_q);
          q_nxt.err_valid = 1'b1;
          q_nxt.st = LPS_CORRECT;
        end
      end
      LPS_CORRECT: begin
        q_nxt.sigma_delta_modulator = q_r.sigma_delta_modulator + step;
        q_nxt.remaining = q_r.remaining - step;
        if (q_r.remaining == PHASE_RST) begin
          q_nxt.cal = 1'b1;
          if (tracking_en) begin
            q_nxt = lps_arm_measure(q_nxt);
          end else begin
            q_nxt.st = LPS_READY;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      q_r <= '0;
      q_r.st <= LPS_IDLE;
      q_r.sref_sync <= SYNC_RST;
      q_r.stage <= STAGE_RST;
      q_r.sigma_delta_modulator <= PHASE_RST;
      q_r.mask <= MASK_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign stage_reset = q_r.rst_pulse;
  assign mcs_done = q_r.done;
  assign sdm_offset = q_r.sigma_delta_modulator;
  assign loop_bw = q_r.bw;
  assign loop_pm = q_r.pm;
  assign desired_phase = q_r.desired_phase_accumulator[FRAC_W-1 -: PHASE_W];
  assign phase_error = q_r.err;
  assign cal_done = q_r.cal;
  assign unlock_irq_mask = q_r.mask;
  assign pll_locked = q_r.locked;

endmodule : lps_phase_sync

// ### testbench/lps_phase_sync_properties.sv
// Concurrent checks on the LO phase sync block ports
`timescale 1ns/1ps
module lps_phase_sync_properties
  import lps_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched signals
  input wire logic lo_program,
  input wire logic [MCS_STAGES-1:0] stage_reset,
  input wire logic mcs_done,
  input wire logic [PHASE_W-1:0] sdm_offset,
  input wire logic [7:0] loop_bw,
  input wire logic [7:0] loop_pm,
  input wire logic [PHASE_W-1:0] phase_error,
  input wire logic cal_done,
  input wire logic [PLL_COUNT-1:0] unlock_irq_mask
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_stage_one_hot: assert property ($onehot0(stage_reset))
    else $error("stage reset not one hot");
  chk_done_last_stage: assert property (stage_reset[3] |-> mcs_done)
    else $error("sync done missing at last stage");
  chk_first_stage_clears: assert property (stage_reset[0] |-> !mcs_done)
    else $error("sync done high at first stage");
  chk_bw_held: assert property (!$past(lo_program) |-> $stable(loop_bw))
    else $error("loop bandwidth moved without programming");
  chk_pm_held: assert property (!$past(lo_program) |-> $stable(loop_pm))
    else $error("phase margin moved without programming");
  chk_unlock_masked: assert property (lo_program |=> unlock_irq_mask == 4'hF)
    else $error("unlock bits not masked while programming");
  chk_step_small: assert property ((sdm_offset - $past(sdm_offset)) <= STEP_MAX
    || ($past(sdm_offset) - sdm_offset) <= STEP_MAX)
    else $error("correction step too large");
  chk_corr_after_est: assert property ($changed(sdm_offset) |-> $past(phase_error) != 16'h0000)
    else $error("correction without estimate");
  chk_done_sticky: assert property (cal_done |=> cal_done)
    else $error("calibration done dropped");
  cov_sync_done: cover property (stage_reset[3]);
endmodule : lps_phase_sync_properties

bind lps_phase_sync lps_phase_sync_properties u_chk (.clk(clk), .rst(rst),
  .lo_program(lo_program), .stage_reset(stage_reset), .mcs_done(mcs_done),
  .sdm_offset(sdm_offset), .loop_bw(loop_bw), .loop_pm(loop_pm),
  .phase_error(phase_error), .cal_done(cal_done), .unlock_irq_mask(unlock_irq_mask));

// ### testbench/lps_clk_source.sv
// Board clock source model giving one sync pulse per request
`timescale 1ns/1ps
module lps_clk_source (
  // Clock and request
  input wire logic clk,
  input wire logic fire,
  // Sync pulse
  output logic sysref
);
  initial sysref = 1'b0;
  always @(posedge clk) begin
    if (fire === 1'b1) begin
      sysref <= #1 1'b1;
      repeat (8) @(posedge clk);
      sysref <= #1 1'b0;
    end
  end
endmodule : lps_clk_source

// ### testbench/tb.sv
// Self-checking bench for the LO phase sync block
`timescale 1ns/1ps
module tb;
  import lps_pkg::*;
  logic clk, rst, sysref, mcs_start, cal_start, tracking_en, lo_program, lo_i, lo_q, fire;
  logic [FRAC_W-1:0] frac_word;
  logic [7:0] loop_bw_set, loop_pm_set, loop_bw, loop_pm, bw, pm;
  logic [PLL_COUNT-1:0] pll_lock_raw, unlock_irq_mask, pll_locked;
  logic [MCS_STAGES-1:0] stage_reset;
  logic mcs_done, cal_done;
  logic [PHASE_W-1:0] sdm_offset, desired_phase, phase_error;
  int failures, tests_run, seed, n;
  int seen [MCS_STAGES];
  lps_phase_sync dut (.clk(clk), .rst(rst), .sysref(sysref), .mcs_start(mcs_start),
    .cal_start(cal_start), .tracking_en(tracking_en), .lo_program(lo_program),
    .frac_word(frac_word), .loop_bw_set(loop_bw_set), .loop_pm_set(loop_pm_set),
    .lo_i(lo_i), .lo_q(lo_q), .pll_lock_raw(pll_lock_raw), .stage_reset(stage_reset),
    .mcs_done(mcs_done), .sdm_offset(sdm_offset), .loop_bw(loop_bw), .loop_pm(loop_pm),
    .desired_phase(desired_phase), .phase_error(phase_error), .cal_done(cal_done),
    .unlock_irq_mask(unlock_irq_mask), .pll_locked(pll_locked));
  lps_clk_source board (.clk(clk), .fire(fire), .sysref(sysref));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic pulse();
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
    cyc(30);
  endtask : pulse
  always @(posedge clk) begin
    for (int k = 0; k < MCS_STAGES; k++) if (stage_reset[k] === 1'b1) seen[k]++;
    #1;
    lo_i = $random(seed);
    lo_q = $random(seed);
    loop_bw_set = $random(seed);
    loop_pm_set = $random(seed);
  end
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 85;
    {rst, mcs_start, cal_start, tracking_en, lo_program, fire} = 6'h20;
    {lo_i, lo_q, loop_bw_set, loop_pm_set, pll_lock_raw} = 22'h000000;
    frac_word = $random(seed);
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    check({mcs_done, cal_done, sdm_offset, unlock_irq_mask}, 0);
    pulse();
    check(seen[0] + seen[1] + seen[2] + seen[3], 0);
    cal_start = 1'b1;
    cyc(1);
    cal_start = 1'b0;
    cyc(300);
    check(cal_done, 0);
    mcs_start = 1'b1;
    cyc(1);
    mcs_start = 1'b0;
    for (int s = 0; s < MCS_STAGES; s++) begin
      pulse();
      check(seen[s], 1);
      check(mcs_done, s == MCS_STAGES - 1);
    end
    lo_program = 1'b1;
    @(posedge clk);
    {bw, pm} = {loop_bw_set, loop_pm_set};
    #1 lo_program = 1'b0;
    check(unlock_irq_mask, 4'hF);
    cyc(5);
    check({loop_bw, loop_pm}, {bw, pm});
    cal_start = 1'b1;
    cyc(1);
    cal_start = 1'b0;
    n = 1;
    while (cal_done !== 1'b1 && n < 5000) begin
      cyc(1);
      n++;
    end
    check(n >= AVG_COUNT && n < 5000, 1);
    tracking_en = 1'b1;
    cyc(600);
    tracking_en = 1'b0;
    check(cal_done, 1);
    for (int j = 0; j < 3; j++) begin
      pll_lock_raw = (j == 0) ? 4'hA : 4'($random(seed));
      cyc(64);
      check(pll_locked, pll_lock_raw);
    end
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    check({mcs_done, cal_done, sdm_offset, loop_bw}, 0);
    check(desired_phase, 0);
    wrap_up();
  end
endmodule : tb
